// file: pkg/temp_readout_pkg.sv
package temp_readout_pkg;

  // ---------------------------------------------------------------
  // Sensor register map (page, address)
  // ---------------------------------------------------------------
  localparam logic [2:0] PG_RESULT   = 3'h2;
  localparam logic [2:0] PG_MODE     = 3'h4;
  localparam logic [2:0] PG_ANALOG   = 3'h6;
  localparam logic [7:0] A_TEMP_HIGH = 8'h0a;
  localparam logic [7:0] A_TEMP_LOW  = 8'h0b;
  localparam logic [7:0] A_MODE_SEL  = 8'h12;
  localparam logic [7:0] A_CFG_A     = 8'h13;
  localparam logic [7:0] A_CFG_B     = 8'h15;
  localparam logic [7:0] A_TRIGGER   = 8'h18;
  localparam logic [7:0] A_FACT_CAL  = 8'h19;

  // ---------------------------------------------------------------
  // Mode codes and acquisition values
  // ---------------------------------------------------------------
  localparam logic [7:0] MODE_GRAY              = 8'hc0;
  localparam logic [7:0] fastest_single_pixel_mode = 8'h01;
  localparam logic [7:0] low_noise_hdr_mode     = 8'h02;
  localparam logic [7:0] range_binned_hdr_mode  = 8'h03;
  localparam logic [7:0] binned_gray_image_mode = 8'h04;
  localparam logic [7:0] CFG_A_SET_MASK = 8'h60;
  localparam logic [7:0] CFG_B_KEEP_MASK = 8'h0f;
  localparam logic [7:0] TRIGGER_GO     = 8'h01;
  localparam logic [7:0] MODE_RESET     = 8'h00;
  localparam logic [7:0] CFG_A_RESET    = 8'h00;
  localparam logic [7:0] CFG_B_RESET    = 8'h30;

  // Minimum double-row read cycles before the result is valid
  localparam logic [2:0] ROWS_FAST  = 3'd1;
  localparam logic [2:0] ROWS_HALF  = 3'd2;
  localparam logic [2:0] ROWS_FULL  = 3'd4;
  localparam int         TEMP_BITS  = 14;
  localparam int         TRIM_POINT_C = 27;

  // ---------------------------------------------------------------
  // Conversion constants, fixed point with 10 fraction bits
  // ---------------------------------------------------------------
  localparam int FRAC_BITS      = 10;
  localparam int RAW_BIAS       = 32'h2000;
  localparam int SLOPE_Q        = 137;
  localparam int CAL_SCALE_Q    = 218;
  localparam int CAL_BIAS       = 32'h12b;
  localparam int CAL_BIAS_Q     = CAL_BIAS * (1 << FRAC_BITS);
  localparam int FILT_DIV       = 10;

  // ---------------------------------------------------------------
  // Controller register offsets (AHB-Lite, byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] R_CTRL     = 8'h00;
  localparam logic [7:0] R_STATUS   = 8'h04;
  localparam logic [7:0] R_RAW      = 8'h08;
  localparam logic [7:0] R_CAL      = 8'h0c;
  localparam logic [7:0] R_TEMP     = 8'h10;
  localparam logic [7:0] R_FILT     = 8'h14;
  localparam logic [7:0] R_MODE_SAV = 8'h18;
  localparam int B_INIT = 0;
  localparam int B_ACQ  = 1;
  localparam int B_BUSY = 0;
  localparam int B_CALV = 1;
  localparam int B_DONE = 2;

  typedef enum logic [4:0] {
    S_IDLE   = 5'b00000, S_RD_A   = 5'b00001, S_RD_B   = 5'b00010,
    S_RD_CAL = 5'b00011, S_RD_M   = 5'b00100, S_WR_A   = 5'b00101,
    S_WR_B   = 5'b00110, S_WR_M   = 5'b00111, S_WR_TRG = 5'b01000,
    S_WAIT   = 5'b01001, S_RD_HI  = 5'b01010, S_RD_LO  = 5'b01011,
    S_RS_A   = 5'b01100, S_RS_B   = 5'b01101, S_RS_M   = 5'b01110,
    S_CALC   = 5'b01111
  } host_state_t;

endpackage

// file: pkg/sensor_reg_if.sv
interface sensor_reg_if;
  import temp_readout_pkg::*;
  logic       req;
  logic       we;
  logic [2:0] page;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       ack;
  logic       frame_busy;

  modport device (input req, we, page, addr, wdata, output rdata, ack, frame_busy);
  modport host   (output req, we, page, addr, wdata, input rdata, ack, frame_busy);
endinterface

// file: core/die_temp_device.sv
module die_temp_device
  import temp_readout_pkg::*;
#(
  parameter logic [7:0]  FACTORY_CAL    = 8'h80,
  parameter logic [13:0] OFFSET_TRIM    = 14'h0000,
  parameter int          ROWS_PER_FRAME = 8
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  sensor_reg_if.device     bus,
  input  wire logic [13:0] temp_raw,
  input  wire logic        row_cycle_done,
  output logic             frame_start,
  output logic             reduced_gain
);
  import temp_readout_pkg::*;

  if (ROWS_PER_FRAME < ROWS_FULL || ROWS_PER_FRAME > 255) begin : g_rows_bad
    $error("ROWS_PER_FRAME out of range");
  end

  logic [7:0]  mode_r;
  logic [7:0]  cfg_a_r;
  logic [7:0]  cfg_b_r;
  logic [7:0]  cal_r;
  logic [15:0] result_r;
  logic        ack_r;
  logic [7:0]  rdata_r;
  logic        busy_r;
  logic [7:0]  rows_r;
  logic        start_r;
  logic [2:0]  need_rows;
  logic [13:0] scaled;
  logic        take;
  logic        trig;

  assign take = bus.req && !ack_r;
  assign trig = take && bus.we && bus.page == PG_RESULT && bus.addr == A_TRIGGER && bus.wdata[0];

  // ---------------------------------------------------------------
  // Mode dependent scaling and wait
  // ---------------------------------------------------------------
  always_comb begin
    unique case (mode_r)
      fastest_single_pixel_mode: begin
        need_rows = ROWS_FAST;
        scaled    = {2'b00, temp_raw[13:2]};                          // [R3]
      end
      low_noise_hdr_mode, range_binned_hdr_mode, binned_gray_image_mode: begin
        need_rows = ROWS_HALF;
        scaled    = {1'b0, temp_raw[13:1]} - {1'b0, OFFSET_TRIM[13:1]}; // [R3]
      end
      default: begin
        need_rows = ROWS_FULL;
        scaled    = temp_raw - OFFSET_TRIM;                           // [R3]
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r  <= MODE_RESET;
      cfg_a_r <= CFG_A_RESET;
      cfg_b_r <= CFG_B_RESET;
      cal_r   <= FACTORY_CAL;  // Reloaded from the trimmed copy, taken at 27 C [R6] [R15]
    end else if (take && bus.we) begin
      if (bus.page == PG_MODE && bus.addr == A_MODE_SEL) begin
        mode_r <= bus.wdata;
      end
      if (bus.page == PG_ANALOG && bus.addr == A_CFG_A) begin
        cfg_a_r <= bus.wdata;
      end
      if (bus.page == PG_ANALOG && bus.addr == A_CFG_B) begin
        cfg_b_r <= bus.wdata;
      end
      if (bus.page == PG_ANALOG && bus.addr == A_FACT_CAL) begin
        cal_r <= bus.wdata;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_r   <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      ack_r <= take;
      if (take && !bus.we) begin
        rdata_r <= 8'h00;
        if (bus.page == PG_RESULT && bus.addr == A_TEMP_HIGH) rdata_r <= result_r[15:8]; // [R4]
        if (bus.page == PG_RESULT && bus.addr == A_TEMP_LOW)  rdata_r <= result_r[7:0];  // [R4]
        if (bus.page == PG_MODE && bus.addr == A_MODE_SEL)    rdata_r <= mode_r;
        if (bus.page == PG_ANALOG && bus.addr == A_CFG_A)     rdata_r <= cfg_a_r;
        if (bus.page == PG_ANALOG && bus.addr == A_CFG_B)     rdata_r <= cfg_b_r;
        if (bus.page == PG_ANALOG && bus.addr == A_FACT_CAL)  rdata_r <= cal_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // Frame sequencing and temperature capture
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_r  <= 1'b0;
      rows_r  <= 8'h00;
      start_r <= 1'b0;
    end else begin
      start_r <= trig && !busy_r;
      if (trig && !busy_r) begin
        busy_r <= 1'b1;
        rows_r <= 8'h00;
      end else if (busy_r && row_cycle_done) begin
        rows_r <= rows_r + 8'h01;
        if (rows_r == 8'(ROWS_PER_FRAME - 1)) begin
          busy_r <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_r <= 16'h0000;
    end else if (trig && !busy_r) begin
      result_r <= 16'h0000;                                  // [R1]
    end else if (busy_r && row_cycle_done && rows_r == {5'b00000, need_rows} - 8'h01) begin
      result_r <= {scaled, 2'b00};                           // [R4] [R17]
    end
  end

  assign bus.ack        = ack_r;
  assign bus.rdata      = rdata_r;
  assign bus.frame_busy = busy_r;
  assign frame_start    = start_r;
  // Gain cut to 1/2.5 while a frame runs in gray mode with config A bits 0x60 set
  assign reduced_gain   = busy_r && mode_r == MODE_GRAY
                          && (cfg_a_r & CFG_A_SET_MASK) == CFG_A_SET_MASK; // [R5]
endmodule

// file: core/temp_host_ctrl.sv
// Notes on behaviour
// R1: Device clears result at every frame start
// R2: Read result after mode's double-row cycles
// R3: Result scaled per mode: /4, /2, full
// R4: Result sits in high and low bytes
// R5: Temperature frame uses 2.5x lower sensitivity
// R6: Calibration byte restored on every reset
// R7: Save both configs, read calibration first (done only on init or before calibration is valid)
// R8: Save mode, write config A with 0x60
// R9: Write config B masked with 0x0f
// R10: Write gray mode, then trigger one
// R11: After readout read high then low byte
// R12: Restore both configs and mode afterwards
// R13: Offset is calibration/4.7 minus 0x12b
// R14: Celsius from bytes, /4, -0x2000, x0.134, +offset
// R15: Sensor offset trimmed at 27 C
// R16: Smooth readings, gain one tenth, seeded first
// R17: Result held stable until next frame
//
// Chosen here: register access over AHB-Lite.
module temp_host_ctrl
  import temp_readout_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  sensor_reg_if.host       bus
);
  import temp_readout_pkg::*;

  host_state_t        state_r;
  host_state_t        state_nxt;
  logic [7:0]         cfg_a_sav_r;
  logic [7:0]         cfg_b_sav_r;
  logic [7:0]         cal_r;
  logic [7:0]         mode_sav_r;
  logic [7:0]         temp_high_byte_r;
  logic [7:0]         temp_low_byte_r;
  logic signed [31:0] temp_r;
  logic signed [31:0] filt_r;
  logic               cal_valid_r;
  logic               done_r;
  logic               seeded_r;
  logic               acq_pend_r;
  logic               wr_ph_r;
  logic [7:0]         addr_ph_r;
  logic               cmd_init;
  logic               cmd_acq;
  logic               bus_state;
  logic signed [31:0] offset_q;
  logic signed [31:0] temp_q;
  logic signed [31:0] raw_q;

  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_r   <= 1'b0;
      addr_ph_r <= 8'h00;
      hrdata    <= 32'h0000_0000;
    end else if (hready) begin
      wr_ph_r   <= hsel && htrans[1] && hwrite;
      addr_ph_r <= haddr[7:0];
      // Registered at the address phase, so read data stands through the whole data phase
      unique case (haddr[7:0])
        R_STATUS:   hrdata <= {29'h0, done_r, cal_valid_r, state_r != S_IDLE};
        R_RAW:      hrdata <= {16'h0000, temp_high_byte_r, temp_low_byte_r};
        R_CAL:      hrdata <= {24'h000000, cal_r};
        R_TEMP:     hrdata <= temp_r;
        R_FILT:     hrdata <= filt_r;
        R_MODE_SAV: hrdata <= {24'h000000, mode_sav_r};
        default:    hrdata <= 32'h0000_0000;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign cmd_init  = wr_ph_r && addr_ph_r == R_CTRL && hwdata[B_INIT];
  assign cmd_acq   = wr_ph_r && addr_ph_r == R_CTRL && hwdata[B_ACQ];

  // ---------------------------------------------------------------
  // Sensor access per sequencer state
  // ---------------------------------------------------------------
  always_comb begin
    bus_state = 1'b1;
    bus.we    = 1'b0;
    bus.page  = PG_ANALOG;
    bus.addr  = A_CFG_A;
    bus.wdata = 8'h00;
    unique case (state_r)
      S_RD_A:   bus.addr = A_CFG_A;                                       // [R7]
      S_RD_B:   bus.addr = A_CFG_B;                                       // [R7]
      S_RD_CAL: bus.addr = A_FACT_CAL;                                    // [R7]
      S_RD_M: begin
        bus.page = PG_MODE;
        bus.addr = A_MODE_SEL;                                            // [R8]
      end
      S_WR_A: begin
        bus.we    = 1'b1;
        bus.wdata = cfg_a_sav_r | CFG_A_SET_MASK;                         // [R8]
      end
      S_WR_B: begin
        bus.we    = 1'b1;
        bus.addr  = A_CFG_B;
        bus.wdata = cfg_b_sav_r & CFG_B_KEEP_MASK;                        // [R9]
      end
      S_WR_M: begin
        bus.we    = 1'b1;
        bus.page  = PG_MODE;
        bus.addr  = A_MODE_SEL;
        bus.wdata = MODE_GRAY;                                            // [R10]
      end
      S_WR_TRG: begin
        bus.we    = 1'b1;
        bus.page  = PG_RESULT;
        bus.addr  = A_TRIGGER;
        bus.wdata = TRIGGER_GO;                                           // [R10]
      end
      S_RD_HI: begin
        bus.page = PG_RESULT;
        bus.addr = A_TEMP_HIGH;                                           // [R11]
      end
      S_RD_LO: begin
        bus.page = PG_RESULT;
        bus.addr = A_TEMP_LOW;                                            // [R11]
      end
      S_RS_A: begin
        bus.we    = 1'b1;
        bus.wdata = cfg_a_sav_r;                                          // [R12]
      end
      S_RS_B: begin
        bus.we    = 1'b1;
        bus.addr  = A_CFG_B;
        bus.wdata = cfg_b_sav_r;                                          // [R12]
      end
      S_RS_M: begin
        bus.we    = 1'b1;
        bus.page  = PG_MODE;
        bus.addr  = A_MODE_SEL;
        bus.wdata = mode_sav_r;                                           // [R12]
      end
      default: bus_state = 1'b0;
    endcase
  end

  assign bus.req = bus_state;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: begin
        if (cmd_init || (cmd_acq && !cal_valid_r)) begin
          state_nxt = S_RD_A;                                             // [R7]
        end else if (cmd_acq) begin
          state_nxt = S_RD_M;
        end
      end
      S_RD_A:   if (bus.ack) state_nxt = S_RD_B;
      S_RD_B:   if (bus.ack) state_nxt = S_RD_CAL;
      S_RD_CAL: if (bus.ack) state_nxt = acq_pend_r ? S_RD_M : S_IDLE;
      S_RD_M:   if (bus.ack) state_nxt = S_WR_A;
      S_WR_A:   if (bus.ack) state_nxt = S_WR_B;
      S_WR_B:   if (bus.ack) state_nxt = S_WR_M;
      S_WR_M:   if (bus.ack) state_nxt = S_WR_TRG;
      S_WR_TRG: if (bus.ack) state_nxt = S_WAIT;
      // Whole frame read out covers the mode's minimum row cycles
      S_WAIT:   if (!bus.frame_busy) state_nxt = S_RD_HI;                 // [R2]
      S_RD_HI:  if (bus.ack) state_nxt = S_RD_LO;
      S_RD_LO:  if (bus.ack) state_nxt = S_RS_A;
      S_RS_A:   if (bus.ack) state_nxt = S_RS_B;
      S_RS_B:   if (bus.ack) state_nxt = S_RS_M;
      S_RS_M:   if (bus.ack) state_nxt = S_CALC;
      S_CALC:   state_nxt = S_IDLE;
      default:  state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acq_pend_r <= 1'b0;
    end else if (state_r == S_IDLE) begin
      acq_pend_r <= cmd_acq;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_a_sav_r <= 8'h00;
      cfg_b_sav_r <= 8'h00;
      cal_r       <= 8'h00;
      mode_sav_r  <= 8'h00;
      temp_high_byte_r <= 8'h00;
      temp_low_byte_r  <= 8'h00;
      cal_valid_r <= 1'b0;
    end else if (bus.ack) begin
      unique case (state_r)
        S_RD_A:   cfg_a_sav_r <= bus.rdata;
        S_RD_B:   cfg_b_sav_r <= bus.rdata;
        S_RD_CAL: begin
          cal_r       <= bus.rdata;
          cal_valid_r <= 1'b1;
        end
        S_RD_M:   mode_sav_r <= bus.rdata;                                 // [R8]
        S_RD_HI:  temp_high_byte_r <= bus.rdata;
        S_RD_LO:  temp_low_byte_r <= bus.rdata;
        default:  cal_valid_r <= cal_valid_r;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Conversion, 10 fraction bits; slope and 1/4.7 rounded to 1/1024
  // ---------------------------------------------------------------
  assign offset_q = $signed({24'h000000, cal_r}) * CAL_SCALE_Q - CAL_BIAS_Q;     // [R13]
  assign raw_q    = $signed({18'h00000, temp_high_byte_r, temp_low_byte_r[7:2]}) - RAW_BIAS; // [R14]
  assign temp_q   = raw_q * SLOPE_Q + offset_q;                                 // [R14]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      temp_r   <= 32'sh0;
      filt_r   <= 32'sh0;
      seeded_r <= 1'b0;
    end else if (state_r == S_CALC) begin
      temp_r   <= temp_q;
      seeded_r <= 1'b1;
      // Divide keeps the small error of one tenth exact enough
      filt_r   <= seeded_r ? filt_r + (temp_q - filt_r) / FILT_DIV : temp_q;  // [R16]
    end
  end

  // Set by a finished conversion wins over a clearing start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_r <= 1'b0;
    end else if (state_r == S_CALC) begin
      done_r <= 1'b1;
    end else if (state_r == S_IDLE && cmd_acq) begin
      done_r <= 1'b0;
    end
  end
endmodule

// file: tb/temp_readout_assertions.sv
module temp_readout_assertions
  import temp_readout_pkg::*;
(
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       req,
  input wire logic       we,
  input wire logic [2:0] page,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       ack,
  input wire logic       frame_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ----
  // Shadow of the host's saved values, updated at each answer
  // ----
  logic        take;
  logic        cal_r;
  logic [7:0]  xa_r, yb_r, ma_r, wa_r, wb_r, wm_r;
  logic [11:0] last_r;
  assign take = req && !ack;

  function automatic logic hit(input logic [2:0] p, input logic [7:0] a);
    return page == p && addr == a;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {cal_r, xa_r, yb_r, ma_r, wa_r, wb_r, wm_r, last_r} <= '0;
    end else if (ack) begin
      last_r <= {we, page, addr};
      if (!we && hit(PG_ANALOG, A_FACT_CAL)) cal_r <= 1'b1;
      if (!we && hit(PG_ANALOG, A_CFG_A)) xa_r <= rdata;
      if (!we && hit(PG_ANALOG, A_CFG_B)) yb_r <= rdata;
      if (!we && hit(PG_MODE, A_MODE_SEL)) ma_r <= rdata;
      if (we && hit(PG_ANALOG, A_CFG_A)) wa_r <= wdata;
      if (we && hit(PG_ANALOG, A_CFG_B)) wb_r <= wdata;
      if (we && hit(PG_MODE, A_MODE_SEL)) wm_r <= wdata;
    end
  end

  // ----
  // Properties
  // ----
  a_ack_follows_req: assert property (take |=> ack)
    else $error("sensor access not answered after one cycle");
  a_ack_one_pulse: assert property (ack |=> !ack)
    else $error("sensor answer longer than one cycle");
  a_req_held: assert property (take |=> req && $stable({we, page, addr, wdata}))
    else $error("sensor request changed before its answer");
  a_cal_first: assert property (take && we && hit(PG_RESULT, A_TRIGGER) |-> cal_r)
    else $error("trigger before calibration read");
  a_cfg_a_forced: assert property (take && we && hit(PG_RESULT, A_TRIGGER) |-> wa_r == (xa_r | CFG_A_SET_MASK))
    else $error("config A not forced before trigger");
  a_cfg_b_masked: assert property (take && we && hit(PG_RESULT, A_TRIGGER) |->
    wb_r == (yb_r & CFG_B_KEEP_MASK))
    else $error("config B not masked before trigger");
  a_gray_trigger: assert property (take && we && hit(PG_RESULT, A_TRIGGER) |->
    wm_r == MODE_GRAY && wdata == TRIGGER_GO)
    else $error("trigger without gray mode or wrong value");
  a_frame_runs: assert property (ack && we && hit(PG_RESULT, A_TRIGGER) |-> ##[0:1] frame_busy)
    else $error("frame did not start after trigger");
  a_read_after_frame: assert property (take && !we && hit(PG_RESULT, A_TEMP_HIGH) |-> !frame_busy)
    else $error("result read while frame running");
  a_low_after_high: assert property (take && !we && hit(PG_RESULT, A_TEMP_LOW) |->
    last_r == {1'b0, PG_RESULT, A_TEMP_HIGH})
    else $error("low byte read not preceded by high byte read");
  a_restore_all: assert property (ack && !we && hit(PG_RESULT, A_TEMP_LOW) |->
    ##[1:3] (we && hit(PG_ANALOG, A_CFG_A) && wdata == xa_r) ##[1:3] (we && hit(PG_ANALOG, A_CFG_B) && wdata == yb_r)
    ##[1:3] (we && hit(PG_MODE, A_MODE_SEL) && wdata == ma_r))
    else $error("saved settings not restored after result read");

  c_trigger: cover property (take && we && hit(PG_RESULT, A_TRIGGER));
  c_low_read: cover property (ack && !we && hit(PG_RESULT, A_TEMP_LOW));
  c_frame_end: cover property ($fell(frame_busy));
endmodule

// file: tb/die_temperature_readout_test.sv
module die_temperature_readout_test;
  import temp_readout_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CAL  = 8'h5a;
  localparam int         ROWS = 4;
  typedef struct { logic [13:0] t; logic [31:0] raw; } row_t;
  row_t rows [4] = '{'{14'h2000, 32'h8000}, '{14'h3fff, 32'hfffc}, '{14'h0000, 32'h0000}, '{14'h1234, 32'h48d0}};

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        frame_start, reduced_gain, seeded;
  logic        row_cycle_done = 1'b0;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [13:0] temp_raw;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          error_cnt, comparisons, y;
  int          nfs = 0, nrg = 0, rc = 0;

  sensor_reg_if bus ();
  temp_host_ctrl i_temp_host_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .bus(bus.host));
  die_temp_device #(.FACTORY_CAL(CAL), .OFFSET_TRIM(14'h0000), .ROWS_PER_FRAME(ROWS)) i_die_temp_device (
    .hclk(hclk), .hresetn(hresetn), .bus(bus.device), .temp_raw(temp_raw), .row_cycle_done(row_cycle_done),
    .frame_start(frame_start), .reduced_gain(reduced_gain));
  temp_readout_assertions i_temp_readout_assertions (.hclk(hclk), .hresetn(hresetn), .req(bus.req), .we(bus.we),
    .page(bus.page), .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .ack(bus.ack),
    .frame_busy(bus.frame_busy));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // ----
  // Pixel readout stand-in: one double-row pulse every fourth cycle of a frame
  // ----
  always @(posedge hclk) begin
    rc <= (bus.frame_busy === 1'b1) ? rc + 1 : 0;
    row_cycle_done <= (bus.frame_busy === 1'b1) && rc % 4 == 2;
    if (frame_start === 1'b1) nfs <= nfs + 1;
    if (frame_start === 1'b1 && reduced_gain === 1'b1) nrg <= nrg + 1;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One single word transfer; entered just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 40);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 80);
    rd = hrdata;
    if (n >= 40) begin
      error_cnt++;
      end_sim();
    end
  endtask

  task automatic wait_done();
    int k;
    for (k = 0; k < 100; k++) begin
      ahb(1'b0, R_STATUS, 32'h0);
      if (rd[B_DONE] === 1'b1 && rd[B_BUSY] === 1'b0) break;
    end
    if (k == 100) begin
      error_cnt++;
      end_sim();
    end
  endtask

  // Full acquisition; a second command sent while busy must be dropped
  task automatic acq_check(input logic [13:0] t, input logic [31:0] raw, input logic dbl);
    int x;
    x = (int'({18'h0, t}) - RAW_BIAS) * SLOPE_Q + int'({24'h0, CAL}) * CAL_SCALE_Q - CAL_BIAS_Q;
    y = seeded ? y + (x - y) / FILT_DIV : x;
    seeded = 1'b1;
    temp_raw <= t;
    ahb(1'b1, R_CTRL, 32'h2);
    if (dbl) ahb(1'b1, R_CTRL, 32'h2);
    wait_done();
    ahb(1'b0, R_RAW, 32'h0);
    check("raw", rd, raw);
    ahb(1'b0, R_TEMP, 32'h0);
    check("temp", rd, x);
    ahb(1'b0, R_FILT, 32'h0);
    check("filt", rd, y);
    ahb(1'b0, R_CAL, 32'h0);
    check("cal", rd, {24'h0, CAL});
    ahb(1'b0, R_MODE_SAV, 32'h0);
    check("mode", rd, {24'h0, MODE_RESET});
  endtask

  initial begin
    #3000000;
    error_cnt++;
    end_sim();
  end

  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, temp_raw, hresetn, seeded} = '0;
    {error_cnt, comparisons, y} = '0;
    hsize = 3'b010;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, R_STATUS, 32'h0);
    check("status", rd, 32'h0);
    ahb(1'b0, R_RAW, 32'h0);
    check("raw", rd, 32'h0);
    ahb(1'b0, 8'h40, 32'h0);
    check("unmapped", rd, 32'h0);
    check("resp", {31'h0, hresp}, 32'h0);
    ahb(1'b1, R_CTRL, 32'h1);
    repeat (8) @(posedge hclk);
    ahb(1'b0, R_STATUS, 32'h0);
    check("status", rd, 32'h2);
    ahb(1'b0, R_CAL, 32'h0);
    check("cal", rd, {24'h0, CAL});
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      acq_check(rows[i].t, rows[i].raw, 1'b0);
      $display("test row %0d done", i);
    end
    check("frames", nfs, 32'd4);
    check("gain", nrg, 32'd4);
    acq_check(14'h2abc, 32'haaf0, 1'b1);
    check("frames", nfs, 32'd5);
    ahb(1'b1, R_RAW, 32'hffffffff);
    ahb(1'b0, R_RAW, 32'h0);
    check("raw", rd, 32'haaf0);
    $display("test busy refusal done");
    ahb(1'b1, R_CTRL, 32'h2);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    seeded = 1'b0;
    ahb(1'b0, R_STATUS, 32'h0);
    check("status", rd, 32'h0);
    acq_check(14'h0abc, 32'h2af0, 1'b0);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule
